/* src/sptun_map.svh */
// Constants for the SPI tunnel over the secondary serial lane
`ifndef SPTUN_MAP_SVH
`define SPTUN_MAP_SVH
`define SPTUN_MODE_FWD      3'h6
`define SPTUN_MODE_REV      3'h7
`define SPTUN_DIV_5M        3'h4
`define SPTUN_DIV_10M       3'h2
`define SPTUN_DIV_20M       3'h1
`define SPTUN_BITS_PER_FRM  6'h25
`define SPTUN_BUF_DEPTH     5'h10
`define SPTUN_BUF_AW        4
`endif

/* src/sptun_pkg.sv */
// Types for the SPI tunnel
package sptun_pkg;
   typedef struct packed {
      logic sclk;
      logic data;
      logic sel_n;
   } sptun_spi_s;
   typedef enum logic [1:0] {
      SPTUN_TX_IDLE = 2'b00,
      SPTUN_TX_SEND = 2'b01
   } sptun_tx_e;
endpackage

/* src/sptun_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sptun_sync2 (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic d_in,
   input  wire logic init_in,
   output var  logic q_out
);
   logic meta;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // Reset to the pin's idle level so no false edge follows reset
         meta  <= init_in;
         q_out <= init_in;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule
`default_nettype wire

/* src/sptun_top.sv */
// SPI tunnel: forward regeneration on pixel clock, reverse capture on oscillator clock
`timescale 1ns/1ps
`default_nettype none
`include "sptun_map.svh"
module sptun_top
   import sptun_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       pix_clk_in,
   input  wire logic       pix_rst_in,
   input  wire logic [2:0] ctrl_channel_mode_field_in,
   input  wire logic       two_lane_in,
   input  wire logic       backchannel_rate_select_in,
   input  wire logic       backchannel_high_speed_in,
   input  wire sptun_spi_s fwd_sample_in,
   input  wire logic       fwd_sample_valid_in,
   input  wire logic       periph_data_in,
   output var  logic       regen_spi_clock_out,
   output var  logic       regen_data_out,
   output var  logic       regen_sel_n_out,
   output var  logic       ret_data_out,
   input  wire logic       ctl_sclk_in,
   input  wire logic       ctl_data_in,
   input  wire logic       ctl_sel_n_in,
   output var  logic       bc_frame_start_out,
   output var  logic       bc_sel_n_out,
   output var  logic       bc_sample_valid_out,
   output var  logic       bc_sample_data_out,
   output var  logic       bc_overflow_out
);
   // =====================================================================
   // Mode decode (configuration arrives quasi-static over I2C)
   // =====================================================================
   logic [2:0] mode_p1;
   logic [2:0] mode_p2;
   logic       lane_p1;
   logic       lane_p2;
   logic       fwd_on;
   always_ff @(posedge pix_clk_in) begin
      if (pix_rst_in) begin
         mode_p1 <= 3'h0;
         mode_p2 <= 3'h0;
         lane_p1 <= 1'b0;
         lane_p2 <= 1'b0;
      end else begin
         mode_p1 <= ctrl_channel_mode_field_in;
         mode_p2 <= mode_p1;
         lane_p1 <= two_lane_in;
         lane_p2 <= lane_p1;
      end
   end
   // Config registers never reachable from this path
   assign fwd_on = lane_p2 && (mode_p2 == `SPTUN_MODE_FWD);

   // =====================================================================
   // Forward regeneration on pixel clock
   // =====================================================================
   sptun_spi_s smp;
   logic       clk_d1;
   always_ff @(posedge pix_clk_in) begin
      if (pix_rst_in) begin
         smp <= '{sclk: 1'b0, data: 1'b0, sel_n: 1'b1};
      end else if (!fwd_on) begin
         smp <= '{sclk: 1'b0, data: 1'b0, sel_n: 1'b1};
      end else if (fwd_sample_valid_in) begin
         smp <= fwd_sample_in;
      end
   end
   always_ff @(posedge pix_clk_in) begin
      if (pix_rst_in) begin
         clk_d1              <= 1'b0;
         regen_spi_clock_out <= 1'b0;
         regen_data_out      <= 1'b0;
         regen_sel_n_out     <= 1'b1;
      end else if (!fwd_on) begin
         clk_d1              <= 1'b0;
         regen_spi_clock_out <= 1'b0;
         regen_data_out      <= 1'b0;
         regen_sel_n_out     <= 1'b1;
      end else begin
         regen_data_out      <= smp.data;
         regen_sel_n_out     <= smp.sel_n;
         clk_d1              <= smp.sclk;
         regen_spi_clock_out <= clk_d1;
      end
   end
   // Peripheral data is asynchronous to the pixel clock
   logic pdat;
   sptun_sync2 u_pdat (
      .clk_in  (pix_clk_in),
      .rst_in  (pix_rst_in),
      .d_in    (periph_data_in),
      .init_in (1'b0),
      .q_out   (pdat)
   );
   always_ff @(posedge pix_clk_in) begin
      if (pix_rst_in) begin
         ret_data_out <= 1'b0;
      end else if (!fwd_on) begin
         ret_data_out <= 1'b0;
      end else if (!regen_spi_clock_out) begin
         ret_data_out <= pdat;
      end
   end

   // =====================================================================
   // Reverse capture on oscillator clock
   // =====================================================================
   logic [2:0] mode_o1;
   logic [2:0] mode_o2;
   logic       lane_o1;
   logic       lane_o2;
   logic       hs_o1;
   logic       hs_o2;
   logic       rs_o1;
   logic       rs_o2;
   logic       rev_on;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         mode_o1 <= 3'h0;
         mode_o2 <= 3'h0;
         lane_o1 <= 1'b0;
         lane_o2 <= 1'b0;
         hs_o1   <= 1'b0;
         hs_o2   <= 1'b0;
         rs_o1   <= 1'b0;
         rs_o2   <= 1'b0;
      end else begin
         mode_o1 <= ctrl_channel_mode_field_in;
         mode_o2 <= mode_o1;
         lane_o1 <= two_lane_in;
         lane_o2 <= lane_o1;
         hs_o1   <= backchannel_high_speed_in;
         hs_o2   <= hs_o1;
         rs_o1   <= backchannel_rate_select_in;
         rs_o2   <= rs_o1;
      end
   end
   assign rev_on = lane_o2 && (mode_o2 == `SPTUN_MODE_REV);

   logic s_sclk;
   logic s_sel_n;
   logic s_data;
   logic sclk_q;
   sptun_sync2 u_sclk (
      .clk_in  (clock_in),
      .rst_in  (rst_in),
      .d_in    (ctl_sclk_in),
      .init_in (1'b0),
      .q_out   (s_sclk)
   );
   sptun_sync2 u_sel (
      .clk_in  (clock_in),
      .rst_in  (rst_in),
      .d_in    (ctl_sel_n_in),
      .init_in (1'b1),
      .q_out   (s_sel_n)
   );
   sptun_sync2 u_data (
      .clk_in  (clock_in),
      .rst_in  (rst_in),
      .d_in    (ctl_data_in),
      .init_in (1'b0),
      .q_out   (s_data)
   );
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= s_sclk;
      end
   end

   // Sample buffer; rising edge taken as active edge
   logic                 buf_mem [`SPTUN_BUF_DEPTH];
   logic [`SPTUN_BUF_AW:0] wr_ptr;
   logic [`SPTUN_BUF_AW:0] rd_ptr;
   logic                 push;
   logic                 pop;
   logic                 buf_empty;
   logic                 buf_full;
   assign push      = rev_on && !s_sel_n && s_sclk && !sclk_q;
   assign buf_empty = (wr_ptr == rd_ptr);
   assign buf_full  = (wr_ptr[`SPTUN_BUF_AW] != rd_ptr[`SPTUN_BUF_AW]) &&
                      (wr_ptr[`SPTUN_BUF_AW-1:0] == rd_ptr[`SPTUN_BUF_AW-1:0]);
   always_ff @(posedge clock_in) begin
      if (push && !buf_full) begin
         buf_mem[wr_ptr[`SPTUN_BUF_AW-1:0]] <= s_data;
      end
   end
   always_ff @(posedge clock_in) begin
      if (rst_in || !rev_on) begin
         wr_ptr          <= '0;
         rd_ptr          <= '0;
         bc_overflow_out <= 1'b0;
      end else begin
         if (push && !buf_full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         // Lost sample shows as a sticky flag until mode exits
         if (push && buf_full) begin
            bc_overflow_out <= 1'b1;
         end
      end
   end

   // =====================================================================
   // Back-channel frame timing
   // =====================================================================
   logic [2:0] div_sel;
   logic [2:0] div_cnt;
   logic       bit_tick;
   logic [5:0] bit_cnt;
   logic       frm_tick;
   always_comb begin
      if (hs_o2) begin
         div_sel = `SPTUN_DIV_20M;
      end else if (rs_o2) begin
         div_sel = `SPTUN_DIV_10M;
      end else begin
         div_sel = `SPTUN_DIV_5M;
      end
   end
   // Compare with >= so a rate change mid-count cannot run the divider past its end
   assign bit_tick = (div_cnt >= div_sel - 3'h1);
   assign frm_tick = bit_tick && (bit_cnt == `SPTUN_BITS_PER_FRM - 6'h1);
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         div_cnt <= 3'h0;
         bit_cnt <= 6'h0;
      end else begin
         div_cnt <= bit_tick ? 3'h0 : div_cnt + 3'h1;
         if (frm_tick) begin
            bit_cnt <= 6'h0;
         end else if (bit_tick) begin
            bit_cnt <= bit_cnt + 6'h1;
         end
      end
   end

   // Send state: one sample per frame at most
   sptun_tx_e tx_state;
   assign pop = rev_on && frm_tick && !buf_empty;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tx_state            <= SPTUN_TX_IDLE;
         bc_frame_start_out  <= 1'b0;
         bc_sel_n_out        <= 1'b1;
         bc_sample_valid_out <= 1'b0;
         bc_sample_data_out  <= 1'b0;
      end else begin
         bc_frame_start_out <= rev_on && frm_tick;
         case (tx_state)
            SPTUN_TX_IDLE: begin
               bc_sel_n_out        <= 1'b1;
               bc_sample_valid_out <= 1'b0;
               bc_sample_data_out  <= 1'b0;
               if (rev_on) begin
                  tx_state <= SPTUN_TX_SEND;
               end
            end
            SPTUN_TX_SEND: begin
               if (!rev_on) begin
                  tx_state <= SPTUN_TX_IDLE;
               end else if (frm_tick) begin
                  bc_sel_n_out        <= s_sel_n;
                  bc_sample_valid_out <= !buf_empty;
                  bc_sample_data_out  <= buf_empty ? 1'b0 : buf_mem[rd_ptr[`SPTUN_BUF_AW-1:0]];
               end
            end
            default: begin
               tx_state <= SPTUN_TX_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* dv/sptun_ctl_model.sv */
// SPI controller model driving the controller pins in reverse mode
`timescale 1ns/1ps
`default_nettype none
module sptun_ctl_model (
   input  wire logic clk_in,
   output var  logic sclk_out,
   output var  logic data_out,
   output var  logic sel_n_out
);
   initial {sclk_out, data_out, sel_n_out} = 3'h1;
   // ====================
   // Write transfer, MSB first; return line ignored so the clock may run fast
   task automatic send(input logic [63:0] bits, input int n, input int half);
      @(posedge clk_in);
      #1 sel_n_out = 0;
      for (int i = n - 1; i >= 0; i--) begin
         data_out = bits[i];
         repeat (half) @(posedge clk_in);
         #1 sclk_out = 1;
         repeat (half) @(posedge clk_in);
         #1 sclk_out = 0;
      end
      repeat (half) @(posedge clk_in);
      #1 sel_n_out = 1;
      // Idle select outlasts a slow frame
      repeat (160) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

/* dv/sptun_top_assertions.sv */
// Port assertions for the SPI tunnel
`timescale 1ns/1ps
`default_nettype none
module sptun_chk
   import sptun_pkg::*;
(
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       pix_clk_in,
   input wire logic       pix_rst_in,
   input wire logic [2:0] ctrl_channel_mode_field_in,
   input wire logic       two_lane_in,
   input wire sptun_spi_s fwd_sample_in,
   input wire logic       fwd_sample_valid_in,
   input wire logic       regen_spi_clock_out,
   input wire logic       regen_data_out,
   input wire logic       regen_sel_n_out,
   input wire logic       ret_data_out,
   input wire logic       bc_frame_start_out,
   input wire logic       bc_sample_valid_out,
   input wire logic       bc_sample_data_out,
   input wire logic       bc_overflow_out
);
   wire [2:0] m = ctrl_channel_mode_field_in;
   // ====================
   // Sequences
   sequence s_take;
      fwd_sample_valid_in && m == 3'h6 && $past(m, 3) == 3'h6 && two_lane_in;
   endsequence
   sequence s_off;
      (m != 3'h6)[*6];
   endsequence
   a_fwd_regen: assert property (@(posedge pix_clk_in) disable iff (pix_rst_in)
      s_take |-> ##2 {regen_data_out, regen_sel_n_out} == $past(fwd_sample_in[1:0], 2)) else $error("fwd regen");
   a_clk_lag: assert property (@(posedge pix_clk_in) disable iff (pix_rst_in)
      s_take |-> ##3 regen_spi_clock_out == $past(fwd_sample_in[2], 3)) else $error("clk lag");
   a_ret_hold: assert property (@(posedge pix_clk_in) disable iff (pix_rst_in)
      regen_spi_clock_out && $past(regen_spi_clock_out) |-> $stable(ret_data_out)) else $error("ret hold");
   a_fwd_idle: assert property (@(posedge pix_clk_in) disable iff (pix_rst_in)
      s_off |-> regen_sel_n_out && !regen_spi_clock_out) else $error("fwd idle");
   a_lane_idle: assert property (@(posedge pix_clk_in) disable iff (pix_rst_in)
      (!two_lane_in)[*6] |-> regen_sel_n_out) else $error("lane idle");
   a_bc_stands: assert property (@(posedge clock_in) disable iff (rst_in)
      (m == 3'h7)[*4] ##0 !bc_frame_start_out |-> $stable({bc_sample_valid_out, bc_sample_data_out}))
      else $error("bc stands");
   a_start_pulse: assert property (@(posedge clock_in) disable iff (rst_in)
      bc_frame_start_out |=> !bc_frame_start_out) else $error("start pulse");
   a_ovf_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
      bc_overflow_out && m == 3'h7 |=> bc_overflow_out) else $error("ovf sticky");
endmodule
bind sptun_top sptun_chk u_chk (.*);
`default_nettype wire

/* dv/sptun_top_bench.sv */
// Self-checking bench for the SPI tunnel
`timescale 1ns/1ps
`default_nettype none
module sptun_top_bench;
   import sptun_pkg::*;
   logic       clock_in = 0, rst_in = 1, pix_clk_in = 0, pix_rst_in = 1, two_lane_in = 1;
   logic [2:0] ctrl_channel_mode_field_in = 3'h0;
   logic       backchannel_rate_select_in = 0, backchannel_high_speed_in = 0, fwd_sample_valid_in = 0;
   sptun_spi_s fwd_sample_in = '0;
   logic       periph_data_in = 0, regen_spi_clock_out, regen_data_out, regen_sel_n_out, ret_data_out;
   logic       ctl_sclk_in, ctl_data_in, ctl_sel_n_in, bc_frame_start_out, bc_sel_n_out, last_sel;
   logic       bc_sample_valid_out, bc_sample_data_out, bc_overflow_out, ovf_run = 0;
   logic       exp_ret = 0, ret_seen = 0;
   logic       pq [$];
   int         bad_count = 0, checks_done = 0, seed = 32'h81C26C3B, gap = 0, per = 148, skip = 2, age = 0;
   sptun_spi_s hist [$];
   logic       exp_q [$];
   always #5 clock_in = ~clock_in;
   initial #3.7 forever #15 pix_clk_in = ~pix_clk_in;
   sptun_top u_dut (.*);
   sptun_ctl_model u_ctl (.clk_in(clock_in), .sclk_out(ctl_sclk_in), .data_out(ctl_data_in), .sel_n_out(ctl_sel_n_in));
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ====================
   // Back-channel model: frame spacing, select and FIFO order of samples
   always @(posedge clock_in) begin
      #1;
      gap++;
      age = (ctl_sel_n_in === last_sel) ? age + 1 : 0;
      last_sel = ctl_sel_n_in;
      if (bc_frame_start_out === 1'h1) begin
         if (skip > 0) skip--;
         else chk("frame_len", gap, per);
         if (age > 12 && ctrl_channel_mode_field_in == 3'h7) chk("bc_sel", bc_sel_n_out, ctl_sel_n_in);
         if (bc_sample_valid_out === 1'h1 && !ovf_run)
            chk("bc_data", bc_sample_data_out, exp_q.size() ? exp_q.pop_front() : 1'hx);
         gap = 0;
      end
   end
   initial begin
      int r, k;
      logic [7:0] b;
      repeat (20) @(posedge clock_in);
      #1 rst_in = 0;
      pix_rst_in = 0;
      ctrl_channel_mode_field_in = 3'h6;
      for (int i = 0; i < 200; i++) begin
         @(posedge pix_clk_in);
         #1;
         if (i > 6) begin
            chk("regen_data", regen_data_out, hist[$-1].data);
            chk("regen_sel", regen_sel_n_out, hist[$-1].sel_n);
            chk("regen_clk", regen_spi_clock_out, hist[$-2].sclk);
            if (!hist[$-3].sclk) begin
               exp_ret = pq[$-2];
               ret_seen = 1;
            end
            if (ret_seen) chk("ret_data", ret_data_out, exp_ret);
         end
         fwd_sample_in = $random(seed);
         fwd_sample_valid_in = 1;
         periph_data_in = $random(seed);
         pq.push_back(periph_data_in);
         hist.push_back(fwd_sample_in);
      end
      fwd_sample_in = 3'h4;
      repeat (4) @(posedge pix_clk_in);
      #1 fwd_sample_valid_in = 0;
      for (r = 0; r < 2; r++) begin
         ctrl_channel_mode_field_in = r ? 3'h6 : 3'h0;
         two_lane_in = !r;
         repeat (8) @(posedge pix_clk_in);
         #1;
         chk("idle_sel", regen_sel_n_out, 1);
         chk("idle_clk", regen_spi_clock_out, 0);
      end
      two_lane_in = 1;
      $display("forward tests done");
      ctrl_channel_mode_field_in = 3'h7;
      for (r = 0; r < 4; r++) begin
         {backchannel_high_speed_in, backchannel_rate_select_in} = r[1:0];
         per = 37 * (r[1] ? 1 : (r[0] ? 2 : 4));
         skip = 2;
         b = $random(seed);
         for (k = 7; k >= 0; k--) exp_q.push_back(b[k]);
         u_ctl.send(b, 8, 90);
         for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clock_in);
         #1 chk("drained", exp_q.size(), 0);
      end
      ovf_run = 1;
      u_ctl.send({$random(seed), $random(seed)}, 48, 4);
      #1 chk("overflow", bc_overflow_out, 1);
      ctrl_channel_mode_field_in = 3'h0;
      repeat (6) @(posedge clock_in);
      #1 chk("ovf_clear", bc_overflow_out, 0);
      $display("reverse tests done");
      finish_test;
   end
   initial begin
      #400000;
      bad_count++;
      finish_test;
   end
endmodule
`default_nettype wire
